// >>> hdl/flash_ctl_pkg.sv
/*
  Constants for the self-programming flash control block: register offsets,
  field positions, reset values, command patterns and window lengths.
  Assumes a 32-bit AXI4-Lite register bus and a single 125 MHz clock.
*/
// How it works
// - ready interrupt requested while arm bit clear
// - read-while-write page op sets busy, blocks section
// - busy clears on re-enable or page load
// - signature read: load returns byte, store ignored
// - re-enable store works only when op done
// - re-enable write during loading discards buffer
// - lock-set store programs locks from low data
// - lock window load returns locks or fuses
// - page write store writes buffer to page
// - write and erase bits clear on completion/timeout
// - no-read-while-write page op stalls the cpu
// - page erase store erases pointer's page
// - plain store loads word into page buffer
// - arm bit: four-cycle window, held during op
// - only single-command low-five-bit patterns take effect; sig bit not checked
// - lock bits return to one only by chip erase or reset
// - no boot section: store needs fuse programmed
// - lock mode two refuses external programming, fuses
// - lock mode three also refuses verify, boot locks
// - application locks gate store writes, boot loads
// - read-lock modes disable interrupts in locked section
// - boot locks gate store writes, application loads
// - pointer upper bits page, bits six:one word
package flash_ctl_pkg;
  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] LOCK_OFFSET = 8'h04;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] LOCK_RESET = 8'hff;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ****************************************************************
  // control field positions
  // ****************************************************************
  localparam int IRQ_EN_BIT = 7;
  localparam int BUSY_BIT = 6;
  localparam int SIG_BIT = 5;
  localparam int REEN_BIT = 4;
  localparam int LOCKSET_BIT = 3;
  localparam int PAGE_WRITE_BIT_BIT = 2;
  localparam int PAGE_ERASE_BIT_BIT = 1;
  localparam int ARM_BIT = 0;
  // ****************************************************************
  // command patterns of the low five bits
  // ****************************************************************
  localparam logic [4:0] CMD_REEN = 5'h11;
  localparam logic [4:0] CMD_LOCKSET = 5'h09;
  localparam logic [4:0] CMD_PAGE_WRITE_BIT = 5'h05;
  localparam logic [4:0] CMD_PAGE_ERASE_BIT = 5'h03;
  localparam logic [4:0] CMD_LOAD = 5'h01;
  // ****************************************************************
  // windows in clock cycles
  // ****************************************************************
  localparam logic [2:0] ARM_CYCLES = 3'h4;
  localparam logic [2:0] READ_CYCLES = 3'h3;
  typedef enum logic [1:0] {st_idle, st_armed, st_busy} ctl_state_e;
endpackage

// >>> hdl/self_program_flash_control.sv
/*
  Self-programming flash controller: control/status register over
  AXI4-Lite, store and load instruction ports from the cpu, the page
  buffer, lock bits and the page operation handshake to the flash array.
  Assumes the cpu raises store/load requests for one cycle and that the
  flash array answers each started page operation with one done pulse.
*/
// Local design decisions: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
module self_program_flash_control
  import flash_ctl_pkg::*;
#(
  parameter int PAGE_W = 8,
  parameter int WORD_W = 6,
  parameter logic [PAGE_W-1:0] BOOT_FIRST_PAGE = 8'he0,
  parameter logic [PAGE_W-1:0] NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE = 8'he0,
  parameter bit HAS_BOOT = 1'b1,
  // arbitrary signature row content
  parameter logic [31:0] SIG_ROW = 32'h5a3c_961e
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // cpu instruction side
  input wire logic store_program_instr,
  input wire logic load_program_instr,
  input wire logic [15:0] pointer,
  input wire logic [15:0] data_register_pair,
  input wire logic exec_from_boot,
  input wire logic vectors_in_boot,
  input wire logic global_irq_flag,
  output logic [7:0] load_data,
  output logic load_hit,
  output logic load_refused,
  output logic ready_irq,
  output logic irq_disable,
  output logic cpu_stall,
  output logic rww_blocked,
  // flash array side
  output logic flash_start,
  output logic flash_erase,
  output logic [PAGE_W-1:0] flash_page,
  input wire logic flash_done,
  input wire logic [WORD_W-1:0] flash_buf_index,
  output logic [15:0] flash_buf_word,
  // fuses, chip erase, external programming gates
  input wire logic self_program_fuse,
  input wire logic [7:0] fuse_low,
  input wire logic chip_erase,
  output logic ext_prog_refused,
  output logic ext_verify_refused,
  output logic fuses_locked,
  output logic boot_locks_locked
);
  import flash_ctl_pkg::*;

  // ****************************************************************
  // decode helpers
  // ****************************************************************
  function automatic logic pattern_ok(input logic [5:0] v);
    pattern_ok = (v[4:0] == CMD_REEN) || (v[4:0] == CMD_LOCKSET) ||
                 (v[4:0] == CMD_PAGE_WRITE_BIT) || (v[4:0] == CMD_PAGE_ERASE_BIT) ||
                 (v[4:0] == CMD_LOAD);
  endfunction

  function automatic logic is_boot(input logic [PAGE_W-1:0] pg);
    is_boot = HAS_BOOT && (pg >= BOOT_FIRST_PAGE);
  endfunction

  // ****************************************************************
  // state
  // ****************************************************************
  ctl_state_e state;
  logic irq_en;
  logic section_busy;
  logic [5:0] cmd;
  logic [2:0] arm_left;
  logic [7:0] lock;
  logic op_no_read_while_write_section;
  logic buf_loaded;
  logic [15:0] page_buf [2**WORD_W];
  logic aw_held, w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  wire logic arm = (state != st_idle);
  wire logic [PAGE_W-1:0] zpage = pointer[WORD_W+PAGE_W:WORD_W+1];
  wire logic [WORD_W-1:0] zword = pointer[WORD_W:1];
  wire logic target_boot = is_boot(zpage);
  wire logic target_no_read_while_write_section = zpage >= NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE;

  // ****************************************************************
  // register bus
  // ****************************************************************
  wire logic wr_fire = aw_held && w_held && !s_axi_bvalid;
  wire logic wr_ctrl = wr_fire && (aw_addr == CTRL_OFFSET) && w_strb[0];
  wire logic wr_map = (aw_addr == CTRL_OFFSET) || (aw_addr == LOCK_OFFSET);
  wire logic [5:0] wr_cmd = w_data[5:0];
  wire logic wr_legal = wr_ctrl && (state != st_busy) && pattern_ok(wr_cmd);
  wire logic [7:0] ctrl_view = {irq_en, section_busy, cmd[5:1], arm};

  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_held) begin
        aw_held <= 1'b1;
        aw_addr <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && !w_held) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_map ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  wire logic [7:0] rd_addr = {s_axi_araddr[7:2], 2'b00};
  always_ff @(posedge clk) begin
    if (!resetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      if (rd_addr == CTRL_OFFSET) begin
        s_axi_rdata <= {24'h000000, ctrl_view};
      end else if (rd_addr == LOCK_OFFSET) begin
        s_axi_rdata <= {24'h000000, lock};
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************************************
  // store and load decode
  // ****************************************************************
  wire logic store_ok = !HAS_BOOT ? !self_program_fuse : 1'b1;
  wire logic store_go = store_program_instr && (state == st_armed) && store_ok;
  // modes 2 and 3 share a programmed low bit
  wire logic write_locked = target_boot ? !lock[4] : !lock[2];
  wire logic page_go = store_go && (cmd[PAGE_WRITE_BIT_BIT] || cmd[PAGE_ERASE_BIT_BIT]) && !write_locked;
  // signature pattern shares the low five bits, its store must not load
  wire logic load_go = store_go && (cmd == {1'b0, CMD_LOAD});
  wire logic reen_go = store_go && cmd[REEN_BIT];
  wire logic lock_go = store_go && cmd[LOCKSET_BIT];
  wire logic timeout = (state == st_armed) && (arm_left == 3'h1) && !store_go;
  wire logic read_win = (state == st_armed) && (arm_left > ARM_CYCLES - READ_CYCLES);

  // ****************************************************************
  // control sequencer
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state <= st_idle;
      irq_en <= CTRL_RESET[IRQ_EN_BIT];
      cmd <= CTRL_RESET[5:0];
      arm_left <= 3'h0;
      op_no_read_while_write_section <= 1'b0;
      flash_start <= 1'b0;
      flash_erase <= 1'b0;
      flash_page <= '0;
    end else begin
      flash_start <= 1'b0;
      if (wr_ctrl) begin
        irq_en <= w_data[IRQ_EN_BIT];
      end
      case (state)
        st_idle: begin
          if (wr_legal) begin
            // window opens in the cycle the write takes effect
            state <= st_armed;
            cmd <= wr_cmd;
            arm_left <= ARM_CYCLES;
          end
        end
        st_armed: begin
          if (page_go) begin
            state <= st_busy;
            flash_start <= 1'b1;
            flash_erase <= cmd[PAGE_ERASE_BIT_BIT];
            flash_page <= zpage;
            op_no_read_while_write_section <= target_no_read_while_write_section;
          end else if (store_go || timeout) begin
            // sig read store lands here and does nothing
            state <= st_idle;
            cmd <= 6'h00;
          end else begin
            arm_left <= arm_left - 3'h1;
          end
        end
        st_busy: begin
          if (flash_done) begin
            state <= st_idle;
            cmd <= 6'h00;
          end
        end
        default: state <= st_idle;
      endcase
    end
  end

  // ****************************************************************
  // section busy flag
  // ****************************************************************
  wire logic busy_set = page_go && !target_no_read_while_write_section;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      section_busy <= 1'b0;
    end else if (busy_set) begin
      section_busy <= 1'b1;
    end else if (load_go || reen_go) begin
      // re-enable can only arm while idle, so the op is over
      section_busy <= 1'b0;
    end
  end

  // ****************************************************************
  // page buffer and lock bits
  // ****************************************************************
  // never while a page op streams the buffer out
  wire logic discard = wr_ctrl && w_data[REEN_BIT] && buf_loaded && (state != st_busy);
  genvar gi;
  generate
    for (gi = 0; gi < 2**WORD_W; gi++) begin : g_buf
      always_ff @(posedge clk) begin
        if (!resetn || discard) begin
          page_buf[gi] <= 16'hffff;
        end else if (load_go && zword == gi) begin
          page_buf[gi] <= data_register_pair;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!resetn || discard) begin
      buf_loaded <= 1'b0;
    end else if (load_go) begin
      buf_loaded <= 1'b1;
    end else if (flash_done && !flash_erase) begin
      buf_loaded <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    flash_buf_word <= page_buf[flash_buf_index];
  end

  // non-volatile in a real part; a reset here models a fresh chip
  always_ff @(posedge clk) begin
    if (!resetn) begin
      lock <= LOCK_RESET;
    end else if (chip_erase) begin
      lock <= LOCK_RESET;
    end else if (lock_go) begin
      lock <= lock & {2'b11, data_register_pair[5:0]};
    end
  end

  // ****************************************************************
  // program load answers
  // ****************************************************************
  wire logic rd_lockwin = load_program_instr && read_win && (cmd[4:0] == CMD_LOCKSET);
  wire logic rd_sig = load_program_instr && read_win && cmd[SIG_BIT];
  wire logic [7:0] sig_byte = SIG_ROW[8*pointer[1:0] +: 8];
  wire logic zpage_boot = target_boot;
  wire logic rd_denied = load_program_instr && !rd_lockwin && !rd_sig &&
      ((exec_from_boot && !zpage_boot && !lock[3]) ||
       (!exec_from_boot && zpage_boot && !lock[5]));

  always_ff @(posedge clk) begin
    if (!resetn) begin
      load_data <= 8'h00;
      load_hit <= 1'b0;
      load_refused <= 1'b0;
    end else begin
      load_hit <= rd_lockwin || rd_sig;
      load_refused <= rd_denied;
      if (rd_lockwin) begin
        load_data <= pointer[0] ? fuse_low : lock;
      end else if (rd_sig) begin
        load_data <= sig_byte;
      end
    end
  end

  // ****************************************************************
  // status outputs
  // ****************************************************************
  assign ready_irq = irq_en && global_irq_flag && !arm;
  assign rww_blocked = section_busy;
  assign cpu_stall = (state == st_busy) && op_no_read_while_write_section;
  assign irq_disable = (!lock[3] && vectors_in_boot && !exec_from_boot) ||
                       (!lock[5] && !vectors_in_boot && exec_from_boot);
  assign ext_prog_refused = !lock[0] || !lock[1];
  assign ext_verify_refused = !lock[0] && !lock[1];
  assign fuses_locked = !lock[0] || !lock[1];
  assign boot_locks_locked = !lock[0] && !lock[1];

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_armed_quiet;
    $rose(arm) ##0 (!store_program_instr)[*4];
  endsequence
  property p_arm_timeout;
    s_armed_quiet |=> !arm;
  endproperty
  a_arm_timeout: assert property (p_arm_timeout) else $error("arm outlived window");

  property p_arm_len;
    $rose(arm) ##0 (!store_program_instr)[*3] |=> arm;
  endproperty
  a_arm_len: assert property (p_arm_len) else $error("arm window too short");

  property p_irq;
    arm |-> !ready_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("ready irq while armed");

  property p_busy_set;
    flash_start && !op_no_read_while_write_section |-> section_busy && rww_blocked;
  endproperty
  a_busy_set: assert property (p_busy_set) else $error("busy flag missed");

  property p_load_clear;
    load_go |=> !section_busy && !arm;
  endproperty
  a_load_clear: assert property (p_load_clear) else $error("load kept busy");

  property p_stall;
    $rose(flash_start) && op_no_read_while_write_section |-> cpu_stall until_with flash_done;
  endproperty
  a_stall: assert property (p_stall) else $error("cpu not stalled");

  property p_lock_mono;
    !chip_erase |=> (lock & ~$past(lock)) == 8'h00;
  endproperty
  a_lock_mono: assert property (p_lock_mono) else $error("lock bit erased");

  property p_lock_read;
    rd_lockwin && !pointer[0] |=> load_hit && load_data == $past(lock);
  endproperty
  a_lock_read: assert property (p_lock_read) else $error("lock read wrong");

  property p_fuse_gate;
    !HAS_BOOT && self_program_fuse |-> !store_go;
  endproperty
  a_fuse_gate: assert property (p_fuse_gate) else $error("store without fuse");

  property p_illegal;
    wr_ctrl && state == st_idle && !pattern_ok(wr_cmd) |=> state == st_idle;
  endproperty
  a_illegal: assert property (p_illegal) else $error("bad pattern armed");
endmodule

// >>> test/flash_array_model.sv
/*
  Flash array stand-in: answers each started page operation with one done
  pulse and keeps the page buffer words streamed out during it.
  Assumes the buffer word follows its index by one clock cycle.
*/
`timescale 1ns/1ps
module flash_array_model (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // page operation handshake
  input wire logic flash_start,
  input wire logic slow,
  output logic flash_done,
  output logic [5:0] flash_buf_index,
  input wire logic [15:0] flash_buf_word,
  // bench view of captured words
  input wire logic [5:0] probe_index,
  output logic [15:0] probe_word
);
  // ****************************************************************
  // page operation
  // ****************************************************************
  logic busy;
  logic [7:0] cnt;
  logic [5:0] idx_q;
  logic [15:0] mem [64];
  assign flash_buf_index = cnt[5:0];
  assign probe_word = mem[probe_index];
  always_ff @(posedge clk) begin
    flash_done <= 1'b0;
    idx_q <= cnt[5:0];
    if (!resetn) begin
      busy <= 1'b0;
      cnt <= 8'h00;
    end else if (flash_start) begin
      busy <= 1'b1;
      cnt <= 8'h00;
    end else if (busy) begin
      cnt <= cnt + 8'h01;
      if (cnt >= 8'h01 && cnt <= 8'h40) mem[idx_q] <= flash_buf_word;
      // slow mode stretches the operation well past the buffer walk
      if (cnt == (slow ? 8'hc8 : 8'h46)) begin
        busy <= 1'b0;
        flash_done <= 1'b1;
      end
    end
  end
endmodule

// >>> test/self_program_flash_control_tb.sv
/*
  Self-checking bench for the self-programming flash control block.
  Assumes the flash array model answers every started page operation.
*/
`timescale 1ns/1ps
module self_program_flash_control_tb;
  import flash_ctl_pkg::*;
  // arbitrary signature row content
  localparam logic [31:0] SIG = 32'h1357_9bdf;
  typedef struct {logic [7:0] cmd; logic [15:0] p; logic st, er, bz, sl;} row_s;
  logic clk, resetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, store, load, exec_boot, vec_boot, gie;
  logic load_hit, load_refused, ready_irq, irq_disable, cpu_stall, rww_blocked;
  logic flash_start, flash_erase, flash_done, chip_erase, slow;
  logic ext_prog, ext_verify, fuses_locked, boot_locked;
  logic [7:0] awaddr, araddr, load_data, flash_page;
  logic [31:0] wdata, rdata, rd;
  logic [1:0] bresp, rresp, rsp;
  logic [15:0] ptr, data, buf_word, probe_word;
  logic [5:0] buf_index, probe_index;
  int num_errors = 0;
  int tests_run = 0;
  row_s rows [7] = '{'{8'h03, 16'h0080, 1'b1, 1'b1, 1'b1, 1'b0},
    '{8'h05, 16'h0100, 1'b1, 1'b0, 1'b1, 1'b0}, '{8'h03, 16'h7000, 1'b1, 1'b1, 1'b0, 1'b1},
    '{8'h07, 16'h0080, 1'b0, 1'b0, 1'b0, 1'b0}, '{8'h01, 16'h0080, 1'b0, 1'b0, 1'b0, 1'b0},
    '{8'h11, 16'h0080, 1'b0, 1'b0, 1'b0, 1'b0}, '{8'h19, 16'h0080, 1'b0, 1'b0, 1'b0, 1'b0}};

  self_program_flash_control #(.SIG_ROW(SIG)) self_program_flash_control_i (
    .clk(clk), .resetn(resetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .store_program_instr(store), .load_program_instr(load), .pointer(ptr),
    .data_register_pair(data), .exec_from_boot(exec_boot), .vectors_in_boot(vec_boot),
    .global_irq_flag(gie), .load_data(load_data), .load_hit(load_hit),
    .load_refused(load_refused), .ready_irq(ready_irq), .irq_disable(irq_disable),
    .cpu_stall(cpu_stall), .rww_blocked(rww_blocked), .flash_start(flash_start),
    .flash_erase(flash_erase), .flash_page(flash_page), .flash_done(flash_done),
    .flash_buf_index(buf_index), .flash_buf_word(buf_word), .self_program_fuse(1'b0),
    .fuse_low(8'ha5), .chip_erase(chip_erase), .ext_prog_refused(ext_prog),
    .ext_verify_refused(ext_verify), .fuses_locked(fuses_locked),
    .boot_locks_locked(boot_locked));

  flash_array_model flash_array_model_i (.clk(clk), .resetn(resetn),
    .flash_start(flash_start), .slow(slow), .flash_done(flash_done),
    .flash_buf_index(buf_index), .flash_buf_word(buf_word), .probe_index(probe_index),
    .probe_word(probe_word));

  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  // ready is looked at on the falling edge, where nothing moves
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok, w_ok, b_ok;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge clk);
      aw_ok = awvalid & awready;
      w_ok = wvalid & wready;
      b_ok = bvalid;
      rsp = bresp;
      @(posedge clk);
      if (aw_ok) awvalid <= 1'b0;
      if (w_ok) wvalid <= 1'b0;
    end while (b_ok !== 1'b1);
    bready <= 1'b0;
  endtask
  task automatic rdr(input logic [7:0] a);
    logic ar_ok, r_ok;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge clk);
      ar_ok = arvalid & arready;
      r_ok = rvalid;
      rd = rdata;
      rsp = rresp;
      @(posedge clk);
      if (ar_ok) arvalid <= 1'b0;
    end while (r_ok !== 1'b1);
    rready <= 1'b0;
  endtask
  // one store or load pulse; returns where its answer has settled
  task automatic cpu(input logic st, input logic [15:0] p, input logic [15:0] d);
    @(posedge clk);
    ptr <= p;
    data <= d;
    store <= st;
    load <= !st;
    @(posedge clk);
    store <= 1'b0;
    load <= 1'b0;
    @(negedge clk);
  endtask
  task automatic wait_done();
    do @(negedge clk); while (flash_done !== 1'b1);
  endtask
  task automatic lockset(input logic [7:0] d);
    wr(CTRL_OFFSET, 32'h09);
    cpu(1'b1, 16'h0000, {8'h00, d});
  endtask
  task automatic reenable();
    wr(CTRL_OFFSET, 32'h11);
    cpu(1'b1, 16'h0000, 16'h0000);
  endtask
  task automatic finish_test();
    $display("comparisons %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ****************************************************************
  // stimulus
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    finish_test();
  end
  initial begin
    {resetn, awvalid, wvalid, bready, arvalid, rready, store, load} = '0;
    {exec_boot, vec_boot, gie, chip_erase, slow} = '0;
    {awaddr, araddr, wdata, ptr, data, probe_index} = '0;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    rdr(CTRL_OFFSET);
    chk(rd, 32'(CTRL_RESET));
    rdr(LOCK_OFFSET);
    chk(rd, 32'(LOCK_RESET));
    rdr(8'h08);
    chk(rd, 32'h0);
    chk(32'(rsp), 32'(RESP_SLVERR));
    wr(8'h0c, 32'h0);
    chk(32'(rsp), 32'(RESP_SLVERR));
    $display("end of reset test");
    foreach (rows[i]) begin
      slow <= (i == 1);
      wr(CTRL_OFFSET, {24'h0, rows[i].cmd});
      cpu(1'b1, rows[i].p, 16'h0);
      chk(32'(flash_start), 32'(rows[i].st));
      chk(32'(rww_blocked), 32'(rows[i].bz));
      chk(32'(cpu_stall), 32'(rows[i].sl));
      if (rows[i].st) begin
        chk(32'(flash_erase), 32'(rows[i].er));
        chk(32'(flash_page), 32'(rows[i].p[14:7]));
        wait_done();
        rdr(CTRL_OFFSET);
        chk(rd, {24'h0, 1'b0, rows[i].bz, 6'h0});
      end
      reenable();
      chk(32'(rww_blocked), 32'h0);
      $display("end of row %0d", i);
    end
    wr(CTRL_OFFSET, 32'h05);
    repeat (2) @(posedge clk);
    cpu(1'b1, 16'h0100, 16'h0);
    chk(32'(flash_start), 32'h0);
    rdr(CTRL_OFFSET);
    chk(rd, 32'h0);
    wr(CTRL_OFFSET, 32'h01);
    @(posedge clk);
    cpu(1'b1, 16'h0006, 16'hbeef);
    wr(CTRL_OFFSET, 32'h05);
    cpu(1'b1, 16'h0100, 16'h0);
    wait_done();
    probe_index <= 6'd3;
    @(posedge clk);
    chk(32'(probe_word), 32'hbeef);
    wr(CTRL_OFFSET, 32'h01);
    cpu(1'b1, 16'h0006, 16'h1234);
    wr(CTRL_OFFSET, 32'h11);
    repeat (6) @(posedge clk);
    wr(CTRL_OFFSET, 32'h05);
    cpu(1'b1, 16'h0100, 16'h0);
    wait_done();
    @(posedge clk);
    chk(32'(probe_word), 32'hffff);
    reenable();
    $display("end of buffer test");
    lockset(8'hf3);
    rdr(LOCK_OFFSET);
    chk(rd, 32'hf3);
    chk(32'(ext_prog), 32'h0);
    wr(CTRL_OFFSET, 32'h09);
    cpu(1'b0, 16'h0000, 16'h0);
    chk(32'({load_hit, load_data}), 32'({1'b1, 8'hf3}));
    wr(CTRL_OFFSET, 32'h09);
    cpu(1'b0, 16'h0001, 16'h0);
    chk(32'({load_hit, load_data}), 32'({1'b1, 8'ha5}));
    wr(CTRL_OFFSET, 32'h05);
    cpu(1'b1, 16'h0100, 16'h0);
    chk(32'(flash_start), 32'h0);
    @(posedge clk);
    exec_boot <= 1'b1;
    cpu(1'b0, 16'h0100, 16'h0);
    chk(32'(load_refused), 32'h1);
    @(posedge clk);
    exec_boot <= 1'b0;
    vec_boot <= 1'b1;
    @(negedge clk);
    chk(32'(irq_disable), 32'h1);
    @(posedge clk);
    vec_boot <= 1'b0;
    lockset(8'hfe);
    chk(32'({ext_prog, ext_verify, fuses_locked}), 32'h5);
    lockset(8'hfc);
    chk(32'({ext_verify, boot_locked}), 32'h3);
    lockset(8'hff);
    rdr(LOCK_OFFSET);
    chk(rd, 32'hf0);
    chip_erase <= 1'b1;
    @(posedge clk);
    chip_erase <= 1'b0;
    rdr(LOCK_OFFSET);
    chk(rd, 32'hff);
    $display("end of lock test");
    gie <= 1'b1;
    wr(CTRL_OFFSET, 32'h80);
    @(negedge clk);
    chk(32'(ready_irq), 32'h1);
    wr(CTRL_OFFSET, 32'h81);
    @(negedge clk);
    chk(32'(ready_irq), 32'h0);
    repeat (6) @(posedge clk);
    @(negedge clk);
    chk(32'(ready_irq), 32'h1);
    wr(CTRL_OFFSET, 32'h21);
    cpu(1'b0, 16'h0002, 16'h0);
    chk(32'({load_hit, load_data}), 32'({1'b1, SIG[23:16]}));
    wr(CTRL_OFFSET, 32'h21);
    cpu(1'b1, 16'h0100, 16'h0);
    chk(32'(flash_start), 32'h0);
    $display("end of interrupt and signature test");
    finish_test();
  end
endmodule
